// [rtl/pmicrb_pkg.sv]
`default_nettype none
package pmicrb_pkg;
  // Register indices
  localparam logic [7:0] ADR_REV   = 8'h00;
  localparam logic [7:0] ADR_OTPV  = 8'h01;
  localparam logic [7:0] ADR_BCK0A = 8'h02;
  localparam logic [7:0] ADR_BCK0B = 8'h03;
  localparam logic [7:0] ADR_PLL   = 8'h14;
  localparam logic [7:0] ADR_PGA   = 8'h15;
  localparam logic [7:0] ADR_PGB   = 8'h16;
  localparam logic [7:0] ADR_PGF   = 8'h17;
  localparam logic [7:0] ADR_SWRST = 8'h18;
  localparam logic [7:0] ADR_INTA  = 8'h19;
  localparam logic [7:0] ADR_INTB  = 8'h1A;
  localparam logic [7:0] ADR_INTBK = 8'h1B;
  localparam logic [7:0] ADR_INTLD = 8'h1C;
  localparam logic [7:0] ADR_TSTAT = 8'h1D;
  localparam logic [7:0] ADR_BSTAT = 8'h1E;
  localparam logic [7:0] ADR_LSTAT = 8'h1F;
  localparam logic [7:0] ADR_MSKA  = 8'h20;
  localparam logic [7:0] ADR_MSKB  = 8'h21;
  localparam logic [7:0] ADR_MSKBK = 8'h22;
  localparam logic [7:0] ADR_MSKLD = 8'h23;
  localparam logic [7:0] ADR_ILSEL = 8'h24;
  localparam logic [7:0] ADR_ILHI  = 8'h25;
  localparam logic [7:0] ADR_ILLO  = 8'h26;
  // Field positions
  localparam int BIT_FPWM    = 3;
  localparam int BIT_RDIS    = 2;
  localparam int BIT_PINGATE = 1;
  localparam int BIT_EN      = 0;
  localparam int BIT_SWRST   = 0;
  // Reset values and valid-bit masks
  localparam logic [7:0] RST_BCK0A = 8'h0F;
  localparam logic [7:0] RST_BCK0B = 8'h2C;
  localparam logic [7:0] RST_RW    = 8'h00;
  localparam logic [5:0] REV_RSVD  = 6'h02;
  localparam logic [7:0] VLD_PGF   = 8'h0F;
  localparam logic [7:0] VLD_TSTAT = 8'h9E;
  localparam logic [7:0] VLD_BLSTAT = 8'hDD;
  localparam logic [7:0] FLAG_ADR [4] = '{ADR_INTA, ADR_INTB, ADR_INTBK, ADR_INTLD};
  localparam logic [7:0] FLAG_VLD [4] = '{8'hFF, 8'h01, 8'h77, 8'h77};
  // Serial address and timing
  localparam logic [6:0] I2C_DEV_ADDR = 7'h60;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OTP_LOAD_NS   = 1000;
  localparam int OTP_LOAD_CYC  = (OTP_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [rtl/pmicrb_i2c_slave.sv]
`default_nettype none
module pmicrb_i2c_slave
  import pmicrb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Serial pins
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Register side
  output logic            wrEn,
  output logic [7:0]      wrData,
  output logic [7:0]      regIndex,
  input  wire logic [7:0] rdData
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEVADR, ST_ACKDEV, ST_INDEX, ST_ACKIDX,
    ST_WRDATA, ST_ACKWR, ST_RDDATA, ST_RDACK
  } pmicrb_i2c_state_t;

  pmicrb_i2c_state_t state_r;
  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic [7:0] shift_r;
  logic [7:0] txShift_r;
  logic [2:0] bitCnt_r;
  logic       byteDone_r;
  logic       rw_r;
  logic       ackSeen_r;
  logic       sdaOe_r;
  logic [7:0] index_r;

  wire sclRise   = scl & ~sclPrev_r;
  wire sclFall   = ~scl & sclPrev_r;
  wire startCond = scl & sclPrev_r & sdaPrev_r & ~sdaIn;
  wire stopCond  = scl & sclPrev_r & ~sdaPrev_r & sdaIn;
  wire rxState   = (state_r == ST_DEVADR) | (state_r == ST_INDEX) | (state_r == ST_WRDATA);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    sclPrev_r <= scl;
    sdaPrev_r <= sdaIn;
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      shift_r    <= 8'h00;
      txShift_r  <= 8'h00;
      bitCnt_r   <= 3'h0;
      byteDone_r <= 1'b0;
      rw_r       <= 1'b0;
      ackSeen_r  <= 1'b0;
      sdaOe_r    <= 1'b0;
      index_r    <= 8'h00;
    end else if (startCond) begin
      state_r    <= ST_DEVADR;
      bitCnt_r   <= 3'h0;
      byteDone_r <= 1'b0;
      sdaOe_r    <= 1'b0;
    end else if (stopCond) begin
      state_r <= ST_IDLE;
      sdaOe_r <= 1'b0;
    end else begin
      if (sclRise && rxState) begin
        shift_r    <= {shift_r[6:0], sdaIn};
        bitCnt_r   <= bitCnt_r + 3'h1;
        byteDone_r <= (bitCnt_r == 3'h7);
      end
      if (sclRise && state_r == ST_RDACK) begin
        ackSeen_r <= ~sdaIn;
      end
      if (sclFall) begin
        unique case (state_r)
          ST_IDLE: ;
          ST_DEVADR: if (byteDone_r) begin
            byteDone_r <= 1'b0;
            if (shift_r[7:1] == DEV_ADDR) begin
              rw_r    <= shift_r[0];
              sdaOe_r <= 1'b1;
              state_r <= ST_ACKDEV;
            end else begin
              state_r <= ST_IDLE;
            end
          end
          ST_INDEX: if (byteDone_r) begin
            byteDone_r <= 1'b0;
            index_r    <= shift_r;
            sdaOe_r    <= 1'b1;
            state_r    <= ST_ACKIDX;
          end
          ST_WRDATA: if (byteDone_r) begin
            byteDone_r <= 1'b0;
            sdaOe_r    <= 1'b1;
            state_r    <= ST_ACKWR;
          end
          ST_ACKDEV: if (rw_r) begin
            txShift_r <= {rdData[6:0], 1'b0};
            sdaOe_r   <= ~rdData[7];
            bitCnt_r  <= 3'h0;
            state_r   <= ST_RDDATA;
          end else begin
            sdaOe_r <= 1'b0;
            state_r <= ST_INDEX;
          end
          ST_ACKIDX: begin
            sdaOe_r <= 1'b0;
            state_r <= ST_WRDATA;
          end
          ST_ACKWR: begin
            sdaOe_r <= 1'b0;
            index_r <= index_r + 8'h01;
            state_r <= ST_WRDATA;
          end
          ST_RDDATA: begin
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7) begin
              sdaOe_r <= 1'b0;
              state_r <= ST_RDACK;
            end else begin
              sdaOe_r   <= ~txShift_r[7];
              txShift_r <= {txShift_r[6:0], 1'b0};
            end
          end
          // Index is kept: a further read byte repeats the same register
          ST_RDACK: if (ackSeen_r) begin
            txShift_r <= {rdData[6:0], 1'b0};
            sdaOe_r   <= ~rdData[7];
            bitCnt_r  <= 3'h0;
            state_r   <= ST_RDDATA;
          end else begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign wrEn     = (state_r == ST_WRDATA) & byteDone_r & sclFall;
  assign wrData   = shift_r;
  assign regIndex = index_r;
  assign sdaOut   = 1'b0;
  assign sdaOe    = sdaOe_r;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence sWrByteDone;
    (state_r == ST_WRDATA) && byteDone_r && sclFall && !startCond;
  endsequence

  AST_WR_ACK: assert property (sWrByteDone |-> wrEn ##1 (state_r == ST_ACKWR && sdaOe))
    else $error("Written byte not acknowledged");
  AST_WR_INC: assert property ((state_r == ST_ACKWR && sclFall && !startCond && !stopCond)
      |=> index_r == $past(index_r) + 8'h01)
    else $error("Index not advanced after write");
  AST_RD_NOINC: assert property ((state_r == ST_RDDATA || state_r == ST_RDACK)
      |=> $stable(index_r))
    else $error("Index moved during read");
  AST_ACK_DEV: assert property (state_r == ST_ACKDEV |-> sdaOe)
    else $error("Device address not acknowledged");
endmodule // pmicrb_i2c_slave
`default_nettype wire

// [rtl/pmicrb_regbank.sv]
`default_nettype none
module pmicrb_regbank
  import pmicrb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = I2C_DEV_ADDR,
  parameter logic [1:0] IDENTITY_FIELD = 2'h1,  // Arbitrary value
  parameter logic [7:0] OTP_VERSION = 8'h5A, // Arbitrary value
  parameter logic [7:0] RST_PLL     = RST_RW,
  parameter logic [7:0] RST_PGA     = RST_RW,
  parameter logic [7:0] RST_PGB     = RST_RW
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Serial pins
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // OTP defaults and load state
  input  wire logic [7:0] otpBuck0A,
  input  wire logic [7:0] otpBuck0B,
  output logic            otpBusy,
  // External enable pin
  input  wire logic       enPin,
  // Status from the analog side
  input  wire logic [3:0] pgFaultIn,
  input  wire logic [7:0] topStatIn,
  input  wire logic [7:0] buckStatIn,
  input  wire logic [7:0] ldoStatIn,
  input  wire logic [8:0] loadCurrent,
  // Event strobes
  input  wire logic [7:0] evtTop,
  input  wire logic [7:0] evtBuck,
  input  wire logic [7:0] evtLdo,
  // Buck0 controls
  output logic            buck0On,
  output logic            buck0ForcedPwm,
  output logic            buck0DischargeOn,
  output logic [7:0]      buck0CtrlB,
  // Other control registers
  output logic [7:0]      pllCtrl,
  output logic [7:0]      pgoodCtrlA,
  output logic [7:0]      pgoodCtrlB,
  output logic            loadCurrentSelect,
  output logic            intPending
);
  //////////////////////////////////////////////////////////////////////////////
  // Serial front end
  logic       wrEn;
  logic [7:0] wrData;
  logic [7:0] regIndex;
  logic [7:0] rdData;

  pmicrb_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .scl      (scl),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .wrEn     (wrEn),
    .wrData   (wrData),
    .regIndex (regIndex),
    .rdData   (rdData)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  logic [7:0] otpCnt_r;
  logic       swRst;
  logic       rwInit;

  // Writes during the OTP load are dropped so the loaded defaults win
  function automatic logic hit(input logic [7:0] adr);
    return wrEn && !otpBusy && (regIndex == adr);
  endfunction

  assign otpBusy = (otpCnt_r != 8'h00);
  assign swRst   = hit(ADR_SWRST) & wrData[BIT_SWRST];
  assign rwInit  = sys_rst | swRst;

  //////////////////////////////////////////////////////////////////////////////
  // OTP load state after reset or software reset
  always_ff @(posedge mclk) begin
    if (rwInit) begin
      otpCnt_r <= 8'(OTP_LOAD_CYC);
    end else if (otpBusy) begin
      otpCnt_r <= otpCnt_r - 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Buck0 control registers, reserved bits stored as written
  logic [7:0] bck0A_r;
  logic [7:0] bck0B_r;

  always_ff @(posedge mclk) begin
    if (rwInit) begin
      bck0A_r <= RST_BCK0A;
      bck0B_r <= RST_BCK0B;
    end else if (otpBusy) begin
      bck0A_r <= otpBuck0A;
      bck0B_r <= otpBuck0B;
    end else begin
      if (hit(ADR_BCK0A)) begin
        bck0A_r <= wrData;
      end
      if (hit(ADR_BCK0B)) begin
        bck0B_r <= wrData;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Plain read/write registers
  logic [7:0] pll_r;
  logic [7:0] pgA_r;
  logic [7:0] pgB_r;
  logic [7:0] mskA_r;
  logic [7:0] mskB_r;
  logic [7:0] mskBk_r;
  logic [7:0] mskLd_r;
  logic [7:0] ilSel_r;

  always_ff @(posedge mclk) begin
    if (rwInit) begin
      pll_r   <= RST_PLL;
      pgA_r   <= RST_PGA;
      pgB_r   <= RST_PGB;
      mskA_r  <= RST_RW;
      mskB_r  <= RST_RW;
      mskBk_r <= RST_RW;
      mskLd_r <= RST_RW;
      ilSel_r <= RST_RW;
    end else begin
      if (hit(ADR_PLL))   pll_r   <= wrData;
      if (hit(ADR_PGA))   pgA_r   <= wrData;
      if (hit(ADR_PGB))   pgB_r   <= wrData;
      if (hit(ADR_MSKA))  mskA_r  <= wrData;
      if (hit(ADR_MSKB))  mskB_r  <= wrData;
      if (hit(ADR_MSKBK)) mskBk_r <= wrData;
      if (hit(ADR_MSKLD)) mskLd_r <= wrData;
      if (hit(ADR_ILSEL)) ilSel_r <= wrData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky event flags, cleared by writing one; a new event beats the clear
  logic [7:0] flag_r [4];
  logic [7:0] flagEvt [4];
  logic [7:0] flagMsk [4];

  assign flagEvt[0] = evtTop;
  assign flagEvt[1] = {7'h00, swRst};
  assign flagEvt[2] = evtBuck;
  assign flagEvt[3] = evtLdo;
  assign flagMsk[0] = mskA_r;
  assign flagMsk[1] = mskB_r;
  assign flagMsk[2] = mskBk_r;
  assign flagMsk[3] = mskLd_r;

  logic [3:0] flagAct;

  for (genvar g = 0; g < 4; g++) begin : g_flag
    wire [7:0] clr = hit(FLAG_ADR[g]) ? wrData : 8'h00;
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        flag_r[g] <= 8'h00;
      end else begin
        flag_r[g] <= ((flag_r[g] & ~clr) | flagEvt[g]) & FLAG_VLD[g];
      end
    end
    assign flagAct[g] = |(flag_r[g] & ~flagMsk[g]);
  end

  assign intPending = |flagAct;

  //////////////////////////////////////////////////////////////////////////////
  // Read selection; reserved bits of read-only registers return zero, those of the revision register return REV_RSVD
  function automatic logic [7:0] rdSel(input logic [7:0] adr);
    unique case (adr)
      ADR_REV:   return {IDENTITY_FIELD, REV_RSVD};
      ADR_OTPV:  return OTP_VERSION;
      ADR_BCK0A: return bck0A_r;
      ADR_BCK0B: return bck0B_r;
      ADR_PLL:   return pll_r;
      ADR_PGA:   return pgA_r;
      ADR_PGB:   return pgB_r;
      ADR_PGF:   return {4'h0, pgFaultIn} & VLD_PGF;
      ADR_INTA:  return flag_r[0];
      ADR_INTB:  return flag_r[1];
      ADR_INTBK: return flag_r[2];
      ADR_INTLD: return flag_r[3];
      ADR_TSTAT: return topStatIn & VLD_TSTAT;
      ADR_BSTAT: return buckStatIn & VLD_BLSTAT;
      ADR_LSTAT: return ldoStatIn & VLD_BLSTAT;
      ADR_MSKA:  return mskA_r;
      ADR_MSKB:  return mskB_r;
      ADR_MSKBK: return mskBk_r;
      ADR_MSKLD: return mskLd_r;
      ADR_ILSEL: return ilSel_r;
      ADR_ILHI:  return {7'h00, loadCurrent[8]};
      ADR_ILLO:  return loadCurrent[7:0];
      default:   return 8'h00;
    endcase
  endfunction

  assign rdData = rdSel(regIndex);

  //////////////////////////////////////////////////////////////////////////////
  // Buck0 control decode
  wire b0Gate = bck0A_r[BIT_PINGATE];
  wire b0En   = bck0A_r[BIT_EN];

  assign buck0On          = b0En & (~b0Gate | enPin);
  assign buck0ForcedPwm   = bck0A_r[BIT_FPWM];
  assign buck0DischargeOn = bck0A_r[BIT_RDIS] & ~buck0On;
  assign buck0CtrlB       = bck0B_r;
  assign pllCtrl          = pll_r;
  assign pgoodCtrlA       = pgA_r;
  assign pgoodCtrlB       = pgB_r;
  assign loadCurrentSelect = ilSel_r[0];

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_FPWM_WR: assert property ((hit(ADR_BCK0A) && !swRst)
      |=> buck0ForcedPwm == $past(wrData[BIT_FPWM]))
    else $error("Forced PWM output does not follow write");
  AST_DISCHARGE: assert property (buck0DischargeOn
      |-> !buck0On && bck0A_r[BIT_RDIS])
    else $error("Discharge resistor on while buck0 active");
  AST_PIN_GATE: assert property ((b0Gate && b0En)
      |-> buck0On == enPin)
    else $error("Pin gating not applied");
  AST_ENABLE: assert property ((!b0Gate || !b0En) |-> buck0On == b0En)
    else $error("Buck0 state differs from enable bit");
  AST_REV_RO: assert property (regIndex == ADR_REV
      |-> rdData[7:6] == IDENTITY_FIELD)
    else $error("Revision identity wrong");
  AST_OTPV_RO: assert property (regIndex == ADR_OTPV |-> rdData == OTP_VERSION)
    else $error("OTP version code wrong");
  AST_OTP_LOAD: assert property ((otpBusy && !swRst)
      |=> bck0A_r == $past(otpBuck0A) && bck0B_r == $past(otpBuck0B))
    else $error("OTP defaults not loaded");
  AST_OTP_LEN: assert property (swRst |=> otpBusy [*8])
    else $error("OTP load state too short");

  //////////////////////////////////////////////////////////////////////////////
  // Software reset: defaults first, then the OTP copy runs again
  sequence sRegsDefault;
    otpBusy && bck0A_r == RST_BCK0A && pll_r == RST_PLL && mskBk_r == RST_RW;
  endsequence

  sequence sOtpCopied;
    bck0A_r == $past(otpBuck0A) && bck0B_r == $past(otpBuck0B);
  endsequence

  AST_SWRST_LOAD: assert property (swRst |=> sRegsDefault ##1 sOtpCopied)
    else $error("Software reset did not restart the OTP load");
  // Flags survive software reset so the host can still see why it ran
  AST_SWRST_FLAG: assert property (swRst |=> flag_r[1][0])
    else $error("Software reset flag not set");
  AST_SWRST_RD: assert property (regIndex == ADR_SWRST |-> rdData == 8'h00)
    else $error("Software reset register not read as zero");

  //////////////////////////////////////////////////////////////////////////////
  // Event flags; a clear in the same cycle as an event must lose
  AST_FLAG_SET: assert property (evtBuck[0] |=> flag_r[2][0])
    else $error("Event flag not set");
  AST_FLAG_CLR: assert property ((hit(ADR_INTBK) && wrData[0] && !evtBuck[0])
      |=> !flag_r[2][0])
    else $error("Event flag not cleared");
  // Summary only; a mask bit of one hides the flag at the same position
  AST_INT_MASK: assert property (((flag_r[2] & ~mskBk_r) != 8'h00) |-> intPending)
    else $error("Unmasked flag does not raise the summary");

  //////////////////////////////////////////////////////////////////////////////
  // Reserved bits of read-only status return zero
  AST_RD_RSVD: assert property (regIndex == ADR_TSTAT
      |-> (rdData & ~VLD_TSTAT) == 8'h00)
    else $error("Reserved status bits not zero");
  AST_RD_ILOAD: assert property (regIndex == ADR_ILHI |-> rdData[7:1] == 7'h00)
    else $error("Reserved load current bits not zero");
endmodule // pmicrb_regbank
`default_nettype wire

// [bench/pmicrb_host_model.sv]
`default_nettype none
module pmicrb_host_model
  import pmicrb_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Serial lines, data is pull-down only
  output logic      scl,
  output logic      sdaPullLow,
  input  wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sdaPullLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Quarter bit is two system clocks so the synchronous sampler sees every level
  task automatic qtr();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic startCond();
    scl = 1'b1;
    qtr();
    sdaPullLow = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic stopCond();
    sdaPullLow = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sdaPullLow = 1'b0;
    qtr();
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaPullLow = !b[i];
      qtr();
      scl = 1'b1;
      qtr();
      qtr();
      scl = 1'b0;
      qtr();
    end
    sdaPullLow = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    ack = (sdaLine === 1'b0);
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic recvByte(output logic [7:0] b, input logic last);
    sdaPullLow = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      qtr();
      scl = 1'b1;
      qtr();
      b[i] = sdaLine;
      qtr();
      scl = 1'b0;
    end
    qtr();
    sdaPullLow = !last;
    qtr();
    scl = 1'b1;
    qtr();
    qtr();
    scl = 1'b0;
    qtr();
    sdaPullLow = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // Callers pass zeros in reserved fields
  task automatic writeRegs(input logic [7:0] idx, input logic [7:0] d [$],
                           output logic ok);
    logic a;
    startCond();
    sendByte({I2C_DEV_ADDR, 1'b0}, ok);
    sendByte(idx, a);
    ok = ok & a;
    foreach (d[k]) begin
      sendByte(d[k], a);
      ok = ok & a;
    end
    stopCond();
  endtask
  // Index is set first, every read names its register
  task automatic readRegs(input logic [7:0] idx, input int n,
                          output logic [7:0] v [$]);
    logic       a;
    logic [7:0] b;
    v = {};
    startCond();
    sendByte({I2C_DEV_ADDR, 1'b0}, a);
    sendByte(idx, a);
    startCond();
    sendByte({I2C_DEV_ADDR, 1'b1}, a);
    for (int k = 0; k < n; k++) begin
      recvByte(b, k == n - 1);
      v.push_back(b);
    end
    stopCond();
  endtask
  task automatic probe(input logic [6:0] adr, output logic ack);
    startCond();
    sendByte({adr, 1'b0}, ack);
    stopCond();
  endtask
endmodule // pmicrb_host_model
`default_nettype wire

// [bench/tb_pmicrb_regbank.sv]
`default_nettype none
module tb_pmicrb_regbank;
  import pmicrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] DEV_ID  = 2'h2;      // Arbitrary value
  localparam logic [7:0] OTP_VER = 8'hC4;     // Arbitrary value
  localparam logic [7:0] OTP_A   = 8'h06;
  localparam logic [7:0] OTP_B   = 8'h1D;
  logic       mclk, sysRst, scl, sdaPullLow, sdaLine, sdaOut, sdaOe, otpBusy, enPin;
  logic [3:0] pgFaultIn;
  logic [7:0] topStatIn, buckStatIn, ldoStatIn, evtTop, evtBuck, evtLdo;
  logic [8:0] loadCurrent;
  logic       buck0On, buck0ForcedPwm, buck0DischargeOn, loadCurrentSelect, intPending;
  logic [7:0] buck0CtrlB, pllCtrl, pgoodCtrlA, pgoodCtrlB;
  int         miscompares = 0;
  int         checks = 0;
  // Open drain line with pull-up
  assign sdaLine = ~(sdaOe | sdaPullLow);
  pmicrb_regbank #(.IDENTITY_FIELD(DEV_ID), .OTP_VERSION(OTP_VER)) pmicrb_regbank_i (
    .mclk(mclk), .sys_rst(sysRst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .otpBuck0A(OTP_A), .otpBuck0B(OTP_B), .otpBusy(otpBusy),
    .enPin(enPin), .pgFaultIn(pgFaultIn), .topStatIn(topStatIn),
    .buckStatIn(buckStatIn), .ldoStatIn(ldoStatIn), .loadCurrent(loadCurrent),
    .evtTop(evtTop), .evtBuck(evtBuck), .evtLdo(evtLdo), .buck0On(buck0On),
    .buck0ForcedPwm(buck0ForcedPwm), .buck0DischargeOn(buck0DischargeOn),
    .buck0CtrlB(buck0CtrlB), .pllCtrl(pllCtrl), .pgoodCtrlA(pgoodCtrlA),
    .pgoodCtrlB(pgoodCtrlB), .loadCurrentSelect(loadCurrentSelect),
    .intPending(intPending));
  pmicrb_host_model pmicrb_host_model_i (
    .mclk(mclk), .scl(scl), .sdaPullLow(sdaPullLow), .sdaLine(sdaLine));
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] exp, input logic [7:0] act);
    checks++;
    if (act !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask
  task automatic check1(input logic exp, input logic act);
    check8({7'h00, exp}, {7'h00, act});
  endtask
  task automatic readOne(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v [$];
    pmicrb_host_model_i.readRegs(idx, 1, v);
    check8(exp, v[0]);
  endtask
  task automatic writeSeq(input logic [7:0] idx, input logic [7:0] d [$]);
    logic ok;
    pmicrb_host_model_i.writeRegs(idx, d, ok);
    check1(1'b1, ok);
  endtask
  ////////////////////////////////////////////////////////////////
  // Identity codes survive writes, buck0 control holds the loaded defaults
  task automatic testIdentity();
    readOne(ADR_BCK0A, OTP_A);
    readOne(ADR_BCK0B, OTP_B);
    check8(OTP_B, buck0CtrlB);
    writeSeq(ADR_REV, '{8'hC0, 8'hFF});
    readOne(ADR_REV, {DEV_ID, REV_RSVD});
    readOne(ADR_OTPV, OTP_VER);
  endtask
  // Burst write lands in consecutive registers, read repeats one register
  task automatic testAutoInc();
    logic [7:0] v [$];
    writeSeq(ADR_PLL, '{8'h45, 8'h3C, 8'h05});
    readOne(ADR_PLL, 8'h45);
    readOne(ADR_PGA, 8'h3C);
    readOne(ADR_PGB, 8'h05);
    check8(8'h45, pllCtrl);
    check8(8'h3C, pgoodCtrlA);
    check8(8'h05, pgoodCtrlB);
    pmicrb_host_model_i.readRegs(ADR_PGA, 2, v);
    check8(8'h3C, v[1]);
  endtask
  // Every combination of the four buck0 bits against both pin levels
  task automatic testBuck();
    logic [3:0] v;
    logic       on;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      writeSeq(ADR_BCK0A, '{{4'h0, v}});
      for (int p = 0; p < 2; p++) begin
        enPin = p[0];
        @(posedge mclk);
        #1;
        on = v[0] & (!v[1] | p[0]);
        check1(v[3], buck0ForcedPwm);
        check1(v[2] & !on, buck0DischargeOn);
        check1(on, buck0On);
      end
    end
  endtask
  // Read-only status, unmapped index and a foreign address
  task automatic testStatus();
    logic ack;
    pgFaultIn = 4'h5;
    topStatIn = 8'hFF;
    loadCurrent = 9'h1C3;
    readOne(ADR_PGF, 8'h05);
    readOne(ADR_TSTAT, 8'h9E);
    readOne(ADR_ILHI, 8'h01);
    readOne(ADR_ILLO, 8'hC3);
    readOne(8'h30, 8'h00);
    writeSeq(ADR_ILSEL, '{8'h01});
    check1(1'b1, loadCurrentSelect);
    check1(1'b0, sdaOut);
    pmicrb_host_model_i.probe(I2C_DEV_ADDR ^ 7'h01, ack);
    check1(1'b0, ack);
  endtask
  // Events latch until cleared by a one; masked flags leave the summary low
  task automatic testFlags();
    check1(1'b0, intPending);
    evtBuck = 8'hFF;
    @(posedge mclk);
    #1;
    evtBuck = 8'h00;
    check1(1'b1, intPending);
    readOne(ADR_INTBK, 8'h77);
    writeSeq(ADR_MSKBK, '{8'hDD});
    check1(1'b1, intPending);
    writeSeq(ADR_INTBK, '{8'h22});
    check1(1'b0, intPending);
    writeSeq(ADR_INTBK, '{8'h55});
    readOne(ADR_INTBK, 8'h00);
  endtask
  // Software reset returns registers to defaults and reloads the OTP bits
  task automatic testSoftReset();
    writeSeq(ADR_SWRST, '{8'h01});
    check8(RST_RW, pllCtrl);
    check1(OTP_A[BIT_FPWM], buck0ForcedPwm);
    readOne(ADR_BCK0A, OTP_A);
    readOne(ADR_INTB, 8'h01);
    readOne(ADR_SWRST, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  // Budget is several times the expected run of about 11000 clocks
  initial begin
    #8_000_000;
    miscompares++;
    complete_run();
  end
  initial begin
    sysRst = 1'b1;
    enPin = 1'b0;
    pgFaultIn = 4'h0;
    topStatIn = 8'h00;
    buckStatIn = 8'h00;
    ldoStatIn = 8'h00;
    loadCurrent = 9'h000;
    evtTop = 8'h00;
    evtBuck = 8'h00;
    evtLdo = 8'h00;
    repeat (3) @(posedge mclk);
    #1;
    sysRst = 1'b0;
    for (int n = 0; n < 40 && otpBusy !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
    check1(1'b0, otpBusy);
    testIdentity();
    testAutoInc();
    testBuck();
    testStatus();
    testFlags();
    testSoftReset();
    complete_run();
  end
endmodule // tb_pmicrb_regbank
`default_nettype wire
